/* timer_compare_unit.sv */
// compare function of a capture/compare unit with register port
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "timer_compare_unit_params.svh"

module timer_compare_unit #(
    parameter bit ENHANCED = 1'b0
) (
    // clock and reset
    input  wire logic            i_clk,
    input  wire logic            i_resetn,
    // register port
    input  wire logic [3:0]      i_addr,
    input  wire tcu_pkg::byte_t  i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output tcu_pkg::byte_t       o_rdata,
    // shared timer and converter
    input  wire tcu_pkg::count_t i_timer_count,
    input  wire logic            i_timer_tick,
    input  wire logic            i_adc_enabled,
    output logic                 o_timer_reset,
    output logic                 o_adc_start,
    output logic                 o_special_trigger,
    // compare pin, two possible locations
    output logic [1:0]           o_pin_out,
    output logic [1:0]           o_pin_oe,
    // interrupt
    output logic                 o_irq
);
    import tcu_pkg::*;

    // ============================================================
    // register state
    byte_t                  module_control;
    byte_t                  compare_value_low;
    byte_t                  compare_value_high;
    logic [`TCU_IRQ_W-1:0]  irq_status;
    logic [`TCU_IRQ_W-1:0]  irq_mask;
    logic                   pin_route_select_a;
    logic                   compare_latch;
    trig_state_t            trig_state;

    // next values
    byte_t                  next_control;
    logic [`TCU_IRQ_W-1:0]  next_status;
    logic [`TCU_IRQ_W-1:0]  next_mask;
    logic                   next_route;
    logic                   next_latch;
    trig_state_t            next_trig;

    // decode and status wires
    logic                   wr_control;
    logic                   wr_cmp_low;
    logic                   wr_cmp_high;
    logic                   wr_status;
    logic                   wr_mask;
    logic                   wr_route;
    byte_t                  ctrl_mask;
    byte_t                  rd_mux;
    match_mode_t            match_mode_field;
    match_mode_t            next_mode;
    logic [1:0]             duty_low_bits;
    logic [1:0]             enhanced_output_config;
    logic                   pin_mode;
    logic                   next_pin_mode;
    logic                   compare_mode;
    logic                   special_mode;
    logic                   control_off;
    count_t                 compare_value;
    logic                   match_equal;
    logic                   match_event;
    logic                   special_event;
    logic                   timer_reset_fire;
    logic [`TCU_IRQ_W-1:0]  irq_set;
    logic [`TCU_IRQ_W-1:0]  irq_clear;

    // ============================================================
    // register write decode
    assign wr_control  = i_wr && (i_addr == `TCU_OFF_CONTROL);
    assign wr_cmp_low  = i_wr && (i_addr == `TCU_OFF_CMP_LOW);
    assign wr_cmp_high = i_wr && (i_addr == `TCU_OFF_CMP_HIGH);
    assign wr_status   = i_wr && (i_addr == `TCU_OFF_IRQ_STATUS);
    assign wr_mask     = i_wr && (i_addr == `TCU_OFF_IRQ_MASK);
    assign wr_route    = i_wr && (i_addr == `TCU_OFF_ROUTE_A);

    // ============================================================
    // control register fields
    // enhanced bits exist only on enhanced modules
    assign ctrl_mask = ENHANCED ? `TCU_CTRL_MASK_ENH : `TCU_CTRL_MASK_STD;
    assign next_control = wr_control ? (i_wdata & ctrl_mask)
                                     : module_control;

    // field views of the control register
    assign match_mode_field =
        match_mode_t'(module_control[`TCU_MODE_MSB:`TCU_MODE_LSB]);
    assign next_mode =
        match_mode_t'(next_control[`TCU_MODE_MSB:`TCU_MODE_LSB]);
    assign duty_low_bits =
        module_control[`TCU_DUTY_MSB:`TCU_DUTY_LSB];
    assign enhanced_output_config =
        module_control[`TCU_ENH_MSB:`TCU_ENH_LSB];

    assign pin_mode = (match_mode_field == MODE_SET)
                   || (match_mode_field == MODE_CLEAR)
                   || (match_mode_field == MODE_TOGGLE);
    assign next_pin_mode = (next_mode == MODE_SET)
                        || (next_mode == MODE_CLEAR)
                        || (next_mode == MODE_TOGGLE);

    // software interrupt and special trigger modes
    assign special_mode = (match_mode_field == MODE_SPECIAL);
    assign compare_mode = pin_mode || special_mode
                       || (match_mode_field == MODE_SW_IRQ);

    // all-zero control write turns the unit off
    assign control_off = wr_control && (i_wdata == `TCU_CTRL_OFF);

    // ============================================================
    // match detection
    // compare value is the high/low byte pair
    assign compare_value = {compare_value_high, compare_value_low};

    // equality against the shared timer, once per new match
    match_detect u_match (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_enable  (compare_mode),
        .i_compare (compare_value),
        .i_count   (i_timer_count),
        .o_equal   (match_equal),
        .o_event   (match_event)
    );

    // special mode match starts the trigger sequence
    assign special_event = match_event && special_mode;

    // ============================================================
    // output latch next value
    // pin action selected by the mode field
    // latch moves on a match event or on an all-zero control write
    always_comb begin
        next_latch = compare_latch;
        if (control_off) begin
            // forced low, port data latch untouched
            next_latch = 1'b0;
        end else if (match_event) begin
            case (match_mode_field)
                MODE_SET: begin
                    next_latch = 1'b1;
                end
                MODE_CLEAR: begin
                    next_latch = 1'b0;
                end
                MODE_TOGGLE: begin
                    next_latch = !compare_latch;
                end
                default: begin
                    next_latch = compare_latch;
                end
            endcase
        end
    end

    // ============================================================
    // timer reset sequencing
    // a match that vanished before the tick cancels
    assign timer_reset_fire = (trig_state == TRIG_ARMED) && special_mode
                           && match_equal && i_timer_tick;

    // armed until the next timer tick or until the match goes away
    always_comb begin
        next_trig = trig_state;
        case (trig_state)
            TRIG_IDLE: begin
                if (special_event) begin
                    next_trig = TRIG_ARMED;
                end
            end
            TRIG_ARMED: begin
                // timer cleared on the next timer edge only
                if (!special_mode || !match_equal || i_timer_tick) begin
                    next_trig = TRIG_IDLE;
                end
            end
            default: begin
                next_trig = TRIG_IDLE;
            end
        endcase
    end

    // ============================================================
    // interrupt status and mask
    // every match in every compare mode raises the flag
    assign irq_set[`TCU_IRQ_MATCH]  = match_event;
    assign irq_set[`TCU_IRQ_TRESET] = timer_reset_fire;
    assign irq_clear = wr_status ? i_wdata[`TCU_IRQ_W-1:0]
                                 : `TCU_IRQ_RESET;
    // a set in the clearing cycle wins, so no event is lost
    assign next_status = (irq_status & ~irq_clear) | irq_set;
    assign next_mask   = wr_mask ? i_wdata[`TCU_IRQ_W-1:0] : irq_mask;

    // ============================================================
    // pin routing
    // route register picks the compare pin location
    assign next_route = wr_route ? i_wdata[0] : pin_route_select_a;

    // ============================================================
    // read data selection; unmapped offsets read zero
    always_comb begin
        rd_mux = `TCU_RDATA_IDLE;
        case (i_addr)
            `TCU_OFF_CONTROL: begin
                rd_mux = module_control;
            end
            `TCU_OFF_CMP_LOW: begin
                rd_mux = compare_value_low;
            end
            `TCU_OFF_CMP_HIGH: begin
                rd_mux = compare_value_high;
            end
            `TCU_OFF_IRQ_STATUS: begin
                rd_mux = {6'h00, irq_status};
            end
            `TCU_OFF_IRQ_MASK: begin
                rd_mux = {6'h00, irq_mask};
            end
            `TCU_OFF_ROUTE_A: begin
                rd_mux = {7'h00, pin_route_select_a};
            end
            `TCU_OFF_LIVE: begin
                rd_mux = {duty_low_bits, enhanced_output_config,
                          trig_state, match_equal, pin_mode,
                          compare_latch};
            end
            default: begin
                rd_mux = `TCU_RDATA_IDLE;
            end
        endcase
    end

    // ============================================================
    // software registers
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            module_control     <= `TCU_CTRL_RESET;
            pin_route_select_a <= `TCU_ROUTE_RESET;
            irq_mask           <= `TCU_IRQ_RESET;
        end else begin
            module_control     <= next_control;
            pin_route_select_a <= next_route;
            irq_mask           <= next_mask;
        end
    end

    // compare value bytes, written one at a time
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            compare_value_low  <= `TCU_CMP_RESET;
            compare_value_high <= `TCU_CMP_RESET;
        end else begin
            if (wr_cmp_low) begin
                compare_value_low <= i_wdata;
            end
            if (wr_cmp_high) begin
                compare_value_high <= i_wdata;
            end
        end
    end

    // ============================================================
    // block state: latch, trigger sequencer, interrupt status
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            compare_latch <= 1'b0;
            trig_state    <= TRIG_IDLE;
            irq_status    <= `TCU_IRQ_RESET;
        end else begin
            compare_latch <= next_latch;
            trig_state    <= next_trig;
            irq_status    <= next_status;
        end
    end

    // ============================================================
    // registered event outputs
    // trigger issued on the match itself, no overflow flag
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_special_trigger <= 1'b0;
            o_adc_start       <= 1'b0;
            o_timer_reset     <= 1'b0;
        end else begin
            o_special_trigger <= special_event;
            // conversion only when the converter is enabled
            o_adc_start       <= special_event && i_adc_enabled;
            o_timer_reset     <= timer_reset_fire;
        end
    end

    // level interrupt follows status and mask with no extra lag
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(next_status & next_mask);
        end
    end

    // registered read data, valid only the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= `TCU_RDATA_IDLE;
        end else begin
            o_rdata <= i_rd ? rd_mux : `TCU_RDATA_IDLE;
        end
    end

    // ============================================================
    // compare pin drivers, one per location
    // the port direction bit still gates the real pad
    genvar loc;
    generate
        for (loc = 0; loc < 2; loc = loc + 1) begin : g_pin
            logic selected;
            assign selected = (next_route == loc[0]);
            always_ff @(posedge i_clk) begin
                if (!i_resetn) begin
                    o_pin_out[loc] <= 1'b0;
                    o_pin_oe[loc]  <= 1'b0;
                end else begin
                    o_pin_out[loc] <= selected && next_latch;
                    // only pin action modes claim the pin
                    o_pin_oe[loc]  <= selected && next_pin_mode;
                end
            end
        end
    endgenerate

endmodule : timer_compare_unit

/* timer_compare_unit_params.svh */
// offsets, field positions and reset values of the compare unit
`ifndef TIMER_COMPARE_UNIT_PARAMS_SVH
`define TIMER_COMPARE_UNIT_PARAMS_SVH

// ============================================================
// register offsets on the 4-bit register port
`define TCU_OFF_CONTROL      4'h0
`define TCU_OFF_CMP_LOW      4'h1
`define TCU_OFF_CMP_HIGH     4'h2
`define TCU_OFF_IRQ_STATUS   4'h3
`define TCU_OFF_IRQ_MASK     4'h4
`define TCU_OFF_ROUTE_A      4'h5
`define TCU_OFF_LIVE         4'h6

// ============================================================
// module_control fields
`define TCU_MODE_MSB         3
`define TCU_MODE_LSB         0
`define TCU_DUTY_MSB         5
`define TCU_DUTY_LSB         4
`define TCU_ENH_MSB          7
`define TCU_ENH_LSB          6
// writable bits: standard module and enhanced module
`define TCU_CTRL_MASK_STD    8'h3F
`define TCU_CTRL_MASK_ENH    8'hFF
// control value that turns the unit off and forces the latch low
`define TCU_CTRL_OFF         8'h00

// ============================================================
// interrupt status and mask bit positions
`define TCU_IRQ_MATCH        0
`define TCU_IRQ_TRESET       1
`define TCU_IRQ_W            2

// ============================================================
// reset values
`define TCU_CTRL_RESET       8'h00
`define TCU_CMP_RESET        8'h00
`define TCU_IRQ_RESET        2'h0
`define TCU_ROUTE_RESET      1'b0
`define TCU_RDATA_IDLE       8'h00

`endif

/* tcu_pkg.sv */
// types shared by the compare unit and its match detector
package tcu_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] count_t;

    // match_mode_field encodings of the compare functions
    typedef enum logic [3:0] {
        MODE_OFF     = 4'b0000,
        MODE_TOGGLE  = 4'b0010,
        MODE_SET     = 4'b1000,
        MODE_CLEAR   = 4'b1001,
        MODE_SW_IRQ  = 4'b1010,
        MODE_SPECIAL = 4'b1011
    } match_mode_t;

    // timer reset sequencing after a special event trigger
    typedef enum logic {
        TRIG_IDLE  = 1'b0,
        TRIG_ARMED = 1'b1
    } trig_state_t;

endpackage : tcu_pkg

/* match_detect.sv */
// 16-bit equality check with a one-cycle event on each new match
`timescale 1ns/10ps

module match_detect (
    // clock and reset
    input  wire logic           i_clk,
    input  wire logic           i_resetn,
    // compare inputs
    input  wire logic           i_enable,
    input  wire tcu_pkg::count_t i_compare,
    input  wire tcu_pkg::count_t i_count,
    // results
    output logic                o_equal,
    output logic                o_event
);
    import tcu_pkg::*;

    logic equal_q;

    // live equality, checked every cycle
    assign o_equal = (i_compare == i_count);

    // a match held over many cycles fires only once
    assign o_event = i_enable && o_equal && !equal_q;

    // remember the qualified equality of the last cycle
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            equal_q <= 1'b0;
        end else begin
            equal_q <= i_enable && o_equal;
        end
    end

endmodule : match_detect

/* timer_compare_unit_asserts.sv */
// port-level checks of the compare unit, bound to its top module
`timescale 1ns/10ps

// ============================================================
// checker
module timer_compare_unit_asserts #(
    parameter bit ENHANCED = 1'b0
) (
    // clock and reset
    input wire logic           i_clk,
    input wire logic           i_resetn,
    // register port
    input wire logic [3:0]     i_addr,
    input wire tcu_pkg::byte_t i_wdata,
    input wire logic           i_wr,
    input wire logic           i_rd,
    input wire tcu_pkg::byte_t o_rdata,
    // timer side and pin
    input wire logic           i_timer_tick,
    input wire logic           o_timer_reset,
    input wire logic           o_adc_start,
    input wire logic           o_special_trigger,
    input wire logic [1:0]     o_pin_out,
    input wire logic [1:0]     o_pin_oe
);
    import tcu_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // control cleared, and control read back
    sequence s_ctrl_off;
        i_wr && i_addr == 4'h0 && i_wdata == 8'h00;
    endsequence
    sequence s_ctrl_rd;
        i_rd && i_addr == 4'h0;
    endsequence

    AST_CTRL_OFF:
        assert property (s_ctrl_off |=> ##[0:1] o_pin_out == 2'h0)
        else $error("pin level not low after control clear");
    AST_CTRL_TOP:
        assert property (s_ctrl_rd |=> ENHANCED || o_rdata[7:6] == 2'h0)
        else $error("enhanced bits read nonzero");
    AST_RD_IDLE:
        assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_TRIG_ONE:
        assert property (o_special_trigger |=> !o_special_trigger)
        else $error("trigger longer than one cycle");
    AST_ADC_WITH_TRIG:
        assert property (o_adc_start |-> o_special_trigger)
        else $error("conversion start without trigger");
    AST_TRIG_NO_PIN:
        assert property (o_special_trigger |-> o_pin_oe == 2'h0)
        else $error("pin claimed in trigger mode");
    AST_TRST_TICK:
        assert property (o_timer_reset |-> $past(i_timer_tick)
                         && !o_special_trigger)
        else $error("timer reset not on a timer tick");
    AST_OE_ONEHOT:
        assert property ($onehot0(o_pin_oe))
        else $error("both pin locations enabled");
    AST_OUT_ONEHOT:
        assert property ($onehot0(o_pin_out))
        else $error("both pin locations driven high");
endmodule : timer_compare_unit_asserts

bind timer_compare_unit timer_compare_unit_asserts #(
    .ENHANCED(ENHANCED)
) timer_compare_unit_asserts_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_timer_tick(i_timer_tick), .o_timer_reset(o_timer_reset),
    .o_adc_start(o_adc_start), .o_special_trigger(o_special_trigger),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe)
);

/* tcu_timer_model.sv */
// behavioural shared timer: count, tick and clear request
`timescale 1ns/10ps

// ============================================================
// timer model
module tcu_timer_model #(
    parameter int TICK_DIV = 4
) (
    // clock and reset
    input  wire logic            i_clk,
    input  wire logic            i_resetn,
    // bench control
    input  wire logic            i_tick_en,
    input  wire logic            i_load,
    input  wire tcu_pkg::count_t i_load_val,
    // device side
    input  wire logic            i_clear,
    output tcu_pkg::count_t      o_count,
    output logic                 o_tick
);
    import tcu_pkg::*;
    int div;

    // tick prescaler, stopped while disabled so loads stay put
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !i_tick_en) begin
            div    <= 0;
            o_tick <= 1'b0;
        end else begin
            div    <= (div == TICK_DIV - 1) ? 0 : div + 1;
            o_tick <= (div == TICK_DIV - 1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn || i_clear)
            o_count <= 16'h0000;
        else if (i_load)
            o_count <= i_load_val;
        else if (o_tick)
            o_count <= o_count + 16'h0001;
    end
endmodule : tcu_timer_model

/* timer_compare_unit_tb_top.sv */
// self-checking bench for the compare unit
`timescale 1ns/10ps

// ============================================================
// bench
module timer_compare_unit_tb_top;
    import tcu_pkg::*;
    logic       clk, resetn, wr, rd, adc_en, tick_en, load, cnt_clr;
    logic       tick, trst, adc, trig, irq;
    logic [3:0] addr;
    logic [1:0] pin_out, pin_oe;
    byte_t      wdata, rdata;
    count_t     cnt, load_val, trig_n, adc_n, trst_n;
    int         bad_count, checked;
    match_mode_t modes [4] = '{MODE_SET, MODE_TOGGLE, MODE_CLEAR,
                               MODE_SW_IRQ};

    timer_compare_unit timer_compare_unit_inst (
        .i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timer_count(cnt),
        .i_timer_tick(tick), .i_adc_enabled(adc_en),
        .o_timer_reset(trst), .o_adc_start(adc),
        .o_special_trigger(trig), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .o_irq(irq));
    tcu_timer_model tcu_timer_model_inst (
        .i_clk(clk), .i_resetn(resetn), .i_tick_en(tick_en),
        .i_load(load), .i_load_val(load_val), .i_clear(trst),
        .o_count(cnt), .o_tick(tick));

    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // pulse counters for the one-cycle outputs
    // one writer only, so a clear never races an increment
    always @(posedge clk) begin
        if (!resetn || cnt_clr) begin
            {trig_n, adc_n, trst_n} <= 48'h0;
        end else begin
            trig_n <= trig_n + 16'(trig);
            adc_n  <= adc_n + 16'(adc);
            trst_n <= trst_n + 16'(trst);
        end
    end

    task automatic check(input logic [15:0] seen, exp, input string s);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, s, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input byte_t d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data sit only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input byte_t e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(16'(rdata), 16'(e), "read");
    endtask : rd_chk

    task automatic load_cnt(input count_t v);
        @(posedge clk);
        load     <= 1'b1;
        load_val <= v;
        @(posedge clk);
        load <= 1'b0;
    endtask : load_cnt

    // leave equality first so the mode write is not itself a match
    task automatic hit(input byte_t ctl, input count_t c);
        wr_reg(4'h2, c[15:8]);
        wr_reg(4'h1, c[7:0]);
        load_cnt(~c);
        wr_reg(4'h0, ctl);
        load_cnt(c);
        repeat (3) @(posedge clk);
        #1;
    endtask : hit

    function automatic logic next_latch(input byte_t ctl, input logic q);
        case (ctl[3:0])
            MODE_SET:    return 1'b1;
            MODE_CLEAR:  return 1'b0;
            MODE_TOGGLE: return ~q;
            default:     return q;
        endcase
    endfunction : next_latch

    function automatic logic pin_mode(input byte_t ctl);
        return ctl[3:0] inside {MODE_SET, MODE_CLEAR, MODE_TOGGLE};
    endfunction : pin_mode

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    // watchdog, well past the expected run of about 500 cycles
    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        end_sim();
    end

    // main sequence
    initial begin
        logic   q;
        logic   r;
        byte_t  ctl;
        count_t c;
        {resetn, wr, rd, adc_en, tick_en, load, cnt_clr} = 7'h00;
        {addr, wdata, load_val} = 28'h0000000;
        void'($urandom(32'h9d0708b5));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        load_cnt(16'hFFFF);
        wr_reg(4'h9, 8'hFF);
        for (int a = 0; a < 16; a++)
            rd_chk(a[3:0], 8'h00);
        wr_reg(4'h0, 8'hFF);
        rd_chk(4'h0, 8'h3F);
        wr_reg(4'h0, 8'h00);
        $display("test registers done");
        q = 1'b0;
        wr_reg(4'h4, 8'h01);
        for (int i = 0; i < 14; i++) begin
            ctl = {2'h0, 2'($urandom), 4'(modes[$urandom_range(3)])};
            c = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
            r = 1'($urandom);
            wr_reg(4'h5, {7'h00, r});
            hit(ctl, c);
            q = next_latch(ctl, q);
            check(16'(irq), 16'h1, "irq on match");
            rd_chk(4'h3, 8'h01);
            rd_chk(4'h0, ctl);
            // bench software keeps the compare pin an output
            check(16'(pin_oe), pin_mode(ctl) ? 16'(2'b01 << r) : 16'h0,
                  "pin enable");
            if (pin_mode(ctl))
                check(16'(pin_out), 16'({1'b0, q} << r), "pin level");
            wr_reg(4'h3, 8'h01);
            repeat (2) @(posedge clk);
            #1;
            check(16'(irq), 16'h0, "irq after clear");
        end
        $display("test compare modes done");
        hit(8'h08, 16'h1234);
        wr_reg(4'h0, 8'h00);
        #1;
        check(16'(pin_out), 16'h0, "latch after control clear");
        wr_reg(4'h4, 8'h00);
        wr_reg(4'h3, 8'h01);
        hit({4'h0, 4'(MODE_SW_IRQ)}, 16'($urandom));
        check(16'(irq), 16'h0, "masked irq");
        rd_chk(4'h3, 8'h01);
        wr_reg(4'h3, 8'h03);
        wr_reg(4'h4, 8'h03);
        $display("test clear and mask done");
        for (int k = 0; k < 3; k++) begin
            adc_en <= k[0];
            cnt_clr <= 1'b1;
            @(posedge clk);
            cnt_clr <= 1'b0;
            c = 16'($urandom_range(16'hF000, 16'h0100));
            hit({4'h0, 4'(MODE_SPECIAL)}, c);
            if (k == 2)
                wr_reg(4'h2, c[15:8] ^ 8'h80);
            tick_en <= 1'b1;
            repeat (10) @(posedge clk);
            tick_en <= 1'b0;
            #1;
            check(trig_n, 16'h1, "trigger count");
            check(adc_n, 16'(k == 1), "conversion start");
            check(trst_n, 16'(k < 2), "timer reset count");
            check(16'(cnt >= c), 16'(k == 2), "timer cleared");
            rd_chk(4'h3, (k < 2) ? 8'h03 : 8'h01);
            wr_reg(4'h3, 8'h03);
        end
        $display("test special trigger done");
        end_sim();
    end
endmodule : timer_compare_unit_tb_top
